// *** rtl/bvc_regs.vh ***
// Register offsets, field positions, masks and reset values for the voice control bank.
`ifndef BVC_REGS_VH
`define BVC_REGS_VH
`define BVC_ADDR_W        5
`define BVC_DATA_W        10
`define BVC_FRAME_W       16
`define BVC_OFF_PWDN1     5'h07
`define BVC_OFF_BBCTL     5'h09
`define BVC_OFF_VULCTL    5'h0A
`define BVC_RST_VAL       10'h000
`define BVC_MASK_PWDN1    10'h3FF
`define BVC_MASK_BBCTL    10'h07F
`define BVC_MASK_VULCTL   10'h1FF
`define BVC_RW_READ       1'h1
`define BVC_BIT_RST       0
`define BVC_BIT_EXTERNAL_CALIBRATION_SEL    1
`define BVC_BIT_DLPD      2
`define BVC_BIT_DLW       3
`define BVC_BIT_ULPD      4
`define BVC_BIT_ULW       5
`define BVC_BIT_MVPD      6
`define BVC_BIT_MVW       7
`define BVC_BIT_LOOP      8
`define BVC_BIT_CMSEL     9
`define BVC_BIT_POL       0
`define BVC_BIT_PHA       1
`define BVC_BIT_DIR       2
`define BVC_BIT_RXCDIR    3
`define BVC_BIT_IDLEZ     4
`define BVC_BIT_TXCONT    5
`define BVC_BIT_BYPASS    6
`define BVC_BIT_VUPON     0
`define BVC_GAIN_LSB      1
`define BVC_BIT_AUX       6
`define BVC_BIT_MIC       7
`define BVC_BIT_BIAS      8
`endif

// *** rtl/bvc_ctrl_regs.v ***
// Serial-accessed control register bank for the baseband and voice codec paths.
//
// Function
// [R1] Codec reset bit holds digital codec reset.
// [R2] Reset fills uplink buffer ones, clears filter.
// [R3] Reset bit sticks until written zero.
// [R4] Calibration select: 0 auto, 1 external.
// [R5] Uplink power-down follows window or bit.
// [R6] Downlink power-down follows window or bit.
// [R7] Mid-voltage driver power-down follows window or bit.
// [R8] Loopback bit connects uplink to downlink terminals.
// [R9] Common-mode select: half supply or 1.35 V.
// [R10] Shift direction: 0 MSB first, 1 LSB.
// [R11] Transmit clock: 0 burst, 1 continuous.
// [R12] Slicer bypass routes master clock around slicer.
// [R13] Pol1 pha1: send falling, sample rising.
// [R14] Pol1 pha0: send early, sample falling.
// [R15] Pol0 pha1: send rising, sample falling.
// [R16] Pol0 pha0: send early, sample rising.
// [R17] Receive clock pin: 0 output, 1 input.
// [R18] Idle transmit pins float or drive low.
// [R19] Amplifier enables act only with uplink power.
// [R20] Microphone bias select: 0 2 V, 1 2.5 V.
// [R21] Five-bit uplink gain code maps to dB.
// [R22] Frame flag: 1 read, 0 write.
// [R23] Reserved reads zero; reset clears; write on completion.
`timescale 1ns/1ns
`include "bvc_regs.vh"
module bvc_ctrl_regs #(
	parameter DATA_W  = `BVC_DATA_W,
	parameter FRAME_W = `BVC_FRAME_W
) (
	// Clock and reset.
	input  wire                 core_clk_in,
	input  wire                 reset_n_in,
	// Control serial link.
	input  wire                 ctl_clk_in,
	input  wire                 ctl_sel_n_in,
	input  wire                 ctl_data_in,
	output reg                  ctl_data_out,
	output reg                  ctl_data_oe_out,
	// Window terminals.
	input  wire                 transmit_window_pin_in,
	input  wire                 receive_window_pin_in,
	// DSP port idle state.
	input  wire                 dsp_port_active_in,
	// Codec path controls.
	output wire                 codec_digital_reset_out,
	output wire                 uplink_buffer_fill_out,
	output wire                 downlink_filter_clear_out,
	output wire                 external_calibration_sel_out,
	output wire                 uplink_power_down_out,
	output wire                 downlink_power_down_out,
	output wire                 midvolt_power_down_out,
	output wire                 baseband_loopback_out,
	output wire                 common_mode_sel_out,
	// Baseband port controls.
	output wire                 shift_lsb_first_out,
	output wire                 tx_clock_continuous_out,
	output wire                 slicer_bypass_out,
	output wire                 serial_clock_polarity_out,
	output wire                 serial_clock_phase_out,
	output wire                 dsp_rx_clock_oe_out,
	output wire                 dsp_tx_pins_oe_out,
	output wire                 dsp_tx_pins_drive_low_out,
	// Voice uplink controls.
	output wire                 voice_up_power_out,
	output wire                 aux_input_amp_en_out,
	output wire                 mic_input_amp_en_out,
	output wire                 mic_bias_sel_out,
	output wire [4:0]           voice_up_gain_code_out,
	output reg  signed [4:0]    voice_up_gain_db_out
);

	reg  [2:0]          clk_sync_reg;
	reg  [1:0]          sel_sync_reg;
	reg  [1:0]          dat_sync_reg;
	reg  [DATA_W-1:0]   pwdn1_reg;
	reg  [DATA_W-1:0]   bbctl_reg;
	reg  [DATA_W-1:0]   vulctl_reg;
	reg  [FRAME_W-1:0]  shift_reg;
	reg  [4:0]          count_reg;
	reg  [DATA_W-1:0]   rd_shift_reg;
	reg                 rd_active_reg;
	reg  [1:0]          txw_sync_reg;
	reg  [1:0]          rxw_sync_reg;
	reg  [1:0]          act_sync_reg;

	wire                clk_rise;
	wire                clk_fall;
	wire                sel_active;
	wire                pol;
	wire                pha;
	wire                lsb_first;
	wire                sample_edge;
	wire                launch_edge;
	wire [FRAME_W-1:0]  frame_next;
	wire [4:0]          count_next;
	wire [4:0]          frame_addr;
	wire                frame_read;
	wire [DATA_W-1:0]   frame_data;
	wire [4:0]          hdr_addr;
	wire                hdr_read;
	wire                rd_load;
	wire                rd_launch;
	wire                txw_open;
	wire                rxw_open;
	wire                port_active;

	// Registers are read back through this mask so reserved bits are always zero.
	function [DATA_W-1:0] bvc_read;
		input [4:0] addr;
		begin
			case (addr)
				`BVC_OFF_PWDN1: bvc_read = pwdn1_reg & `BVC_MASK_PWDN1;
				`BVC_OFF_BBCTL: bvc_read = bbctl_reg & `BVC_MASK_BBCTL;
				`BVC_OFF_VULCTL: bvc_read = vulctl_reg & `BVC_MASK_VULCTL;
				default: bvc_read = `BVC_RST_VAL;
			endcase
		end
	endfunction

	// Word order is data in the top ten bits, address next, flag last, as sent.
	function [FRAME_W-1:0] bvc_shift;
		input [FRAME_W-1:0] cur;
		input               bit_in;
		input               lsb;
		begin
			if (lsb) begin
				bvc_shift = {bit_in, cur[FRAME_W-1:1]};
			end else begin
				bvc_shift = {cur[FRAME_W-2:0], bit_in};
			end
		end
	endfunction

	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clk_sync_reg <= 3'h0;
			sel_sync_reg <= 2'h3;
			dat_sync_reg <= 2'h0;
			txw_sync_reg <= 2'h0;
			rxw_sync_reg <= 2'h0;
			act_sync_reg <= 2'h0;
		end else begin
			clk_sync_reg <= {clk_sync_reg[1:0], ctl_clk_in};
			sel_sync_reg <= {sel_sync_reg[0], ctl_sel_n_in};
			dat_sync_reg <= {dat_sync_reg[0], ctl_data_in};
			txw_sync_reg <= {txw_sync_reg[0], transmit_window_pin_in};
			rxw_sync_reg <= {rxw_sync_reg[0], receive_window_pin_in};
			act_sync_reg <= {act_sync_reg[0], dsp_port_active_in};
		end
	end

	// The window and port pins are asynchronous, so the outputs follow them two cycles late.
	assign txw_open    = txw_sync_reg[1];
	assign rxw_open    = rxw_sync_reg[1];
	assign port_active = act_sync_reg[1];

	assign clk_rise   = clk_sync_reg[1] & ~clk_sync_reg[2];
	assign clk_fall   = ~clk_sync_reg[1] & clk_sync_reg[2];
	assign sel_active = ~sel_sync_reg[1];
	assign pol        = bbctl_reg[`BVC_BIT_POL];
	assign pha        = bbctl_reg[`BVC_BIT_PHA];
	assign lsb_first  = bbctl_reg[`BVC_BIT_DIR]; // see [R10]

	// Polarity XOR phase picks the sampling edge; the launch edge is the other one.
	assign sample_edge = (pol ^ pha) ? clk_fall : clk_rise; // see [R13] see [R14] see [R15] see [R16]
	// Read data always moves on the edge opposite the sampling edge, half a period ahead.
	assign launch_edge = (pol ^ pha) ? clk_rise : clk_fall; // see [R13] see [R14] see [R15] see [R16]

	assign frame_next = bvc_shift(shift_reg, dat_sync_reg[1], lsb_first);
	assign count_next = count_reg + 5'h01;
	assign frame_addr = lsb_first ? frame_next[5:1] : frame_next[5:1];
	assign frame_read = frame_next[0] == `BVC_RW_READ; // see [R22]
	assign frame_data = frame_next[FRAME_W-1:FRAME_W-DATA_W];

	// Reads work only LSB-first, where the header leads; an MSB-first read frame is ignored.
	assign hdr_addr  = frame_next[FRAME_W-1:FRAME_W-5];
	assign hdr_read  = frame_next[FRAME_W-6] == `BVC_RW_READ; // see [R22]
	assign rd_load   = sample_edge && count_next == 5'h06 && lsb_first && hdr_read;
	assign rd_launch = launch_edge && rd_active_reg && count_reg < FRAME_W[4:0];

	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			shift_reg <= {FRAME_W{1'b0}};
			count_reg <= 5'h00;
			pwdn1_reg <= `BVC_RST_VAL; // see [R23]
			bbctl_reg <= `BVC_RST_VAL;
			vulctl_reg <= `BVC_RST_VAL;
		end else if (!sel_active) begin
			count_reg <= 5'h00;
		end else if (sample_edge && count_reg < FRAME_W[4:0]) begin
			shift_reg <= frame_next;
			count_reg <= count_next;
			// A write lands only when its last bit has arrived; a cut frame changes nothing.
			if (count_next == FRAME_W[4:0] && !frame_read) begin // see [R23]
				case (frame_addr)
					`BVC_OFF_PWDN1: pwdn1_reg <= frame_data & `BVC_MASK_PWDN1; // see [R3]
					`BVC_OFF_BBCTL: bbctl_reg <= frame_data & `BVC_MASK_BBCTL;
					`BVC_OFF_VULCTL: vulctl_reg <= frame_data & `BVC_MASK_VULCTL;
					default: pwdn1_reg <= pwdn1_reg;
				endcase
			end
		end
	end

	// Read data follows the six header bits, so it is loaded once the address is in.
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_shift_reg <= `BVC_RST_VAL;
			rd_active_reg <= 1'b0;
			ctl_data_out <= 1'b0;
			ctl_data_oe_out <= 1'b0;
		end else if (!sel_active) begin
			rd_active_reg <= 1'b0;
			ctl_data_oe_out <= 1'b0;
		end else if (rd_load) begin
			rd_shift_reg <= bvc_read(hdr_addr); // see [R23]
			rd_active_reg <= 1'b1;
		end else if (rd_launch) begin
			ctl_data_oe_out <= 1'b1;
			ctl_data_out <= lsb_first ? rd_shift_reg[0] : rd_shift_reg[DATA_W-1];
			rd_shift_reg <= lsb_first ? {1'b0, rd_shift_reg[DATA_W-1:1]}
				: {rd_shift_reg[DATA_W-2:0], 1'b0};
		end
	end

	assign codec_digital_reset_out      = pwdn1_reg[`BVC_BIT_RST]; // see [R1] see [R3]
	assign uplink_buffer_fill_out       = pwdn1_reg[`BVC_BIT_RST]; // see [R2]
	assign downlink_filter_clear_out    = pwdn1_reg[`BVC_BIT_RST]; // see [R2]
	assign external_calibration_sel_out = pwdn1_reg[`BVC_BIT_EXTERNAL_CALIBRATION_SEL]; // see [R4]
	assign uplink_power_down_out = pwdn1_reg[`BVC_BIT_ULW] ? pwdn1_reg[`BVC_BIT_ULPD]
		: ~txw_open; // see [R5]
	assign downlink_power_down_out = pwdn1_reg[`BVC_BIT_DLW] ? pwdn1_reg[`BVC_BIT_DLPD]
		: ~rxw_open; // see [R6]
	assign midvolt_power_down_out = pwdn1_reg[`BVC_BIT_MVW] ? pwdn1_reg[`BVC_BIT_MVPD]
		: ~txw_open; // see [R7]
	assign baseband_loopback_out   = pwdn1_reg[`BVC_BIT_LOOP]; // see [R8]
	assign common_mode_sel_out     = pwdn1_reg[`BVC_BIT_CMSEL]; // see [R9]

	assign shift_lsb_first_out       = lsb_first;
	assign tx_clock_continuous_out   = bbctl_reg[`BVC_BIT_TXCONT]; // see [R11]
	assign slicer_bypass_out         = bbctl_reg[`BVC_BIT_BYPASS]; // see [R12]
	assign serial_clock_polarity_out = pol;
	assign serial_clock_phase_out    = pha;
	assign dsp_rx_clock_oe_out       = ~bbctl_reg[`BVC_BIT_RXCDIR]; // see [R17]
	// Idle pins either float or are pulled to ground by the pad driving low.
	assign dsp_tx_pins_oe_out = port_active | ~bbctl_reg[`BVC_BIT_IDLEZ]; // see [R18]
	assign dsp_tx_pins_drive_low_out = ~port_active & ~bbctl_reg[`BVC_BIT_IDLEZ]; // see [R18]

	assign voice_up_power_out   = vulctl_reg[`BVC_BIT_VUPON];
	assign aux_input_amp_en_out = vulctl_reg[`BVC_BIT_VUPON] & vulctl_reg[`BVC_BIT_AUX]; // see [R19]
	assign mic_input_amp_en_out = vulctl_reg[`BVC_BIT_VUPON] & vulctl_reg[`BVC_BIT_MIC]; // see [R19]
	assign mic_bias_sel_out     = vulctl_reg[`BVC_BIT_BIAS]; // see [R20]
	assign voice_up_gain_code_out = vulctl_reg[`BVC_GAIN_LSB+4:`BVC_GAIN_LSB];

	// Unlisted codes fall back to the lowest gain, which is the safe choice for a microphone.
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			voice_up_gain_db_out <= 5'h1A;
		end else begin
			case (vulctl_reg[`BVC_GAIN_LSB+4:`BVC_GAIN_LSB]) // see [R21]
				5'h00: voice_up_gain_db_out <= 5'h1A;
				5'h01: voice_up_gain_db_out <= 5'h1B;
				5'h02: voice_up_gain_db_out <= 5'h1C;
				5'h03: voice_up_gain_db_out <= 5'h1D;
				5'h04: voice_up_gain_db_out <= 5'h1E;
				5'h05: voice_up_gain_db_out <= 5'h1F;
				5'h06: voice_up_gain_db_out <= 5'h00;
				5'h07: voice_up_gain_db_out <= 5'h01;
				5'h08: voice_up_gain_db_out <= 5'h02;
				5'h09: voice_up_gain_db_out <= 5'h03;
				5'h0A: voice_up_gain_db_out <= 5'h04;
				5'h0B: voice_up_gain_db_out <= 5'h05;
				5'h0C: voice_up_gain_db_out <= 5'h06;
				5'h10: voice_up_gain_db_out <= 5'h14;
				5'h11: voice_up_gain_db_out <= 5'h07;
				5'h12: voice_up_gain_db_out <= 5'h08;
				5'h13: voice_up_gain_db_out <= 5'h09;
				5'h14: voice_up_gain_db_out <= 5'h0A;
				5'h15: voice_up_gain_db_out <= 5'h0B;
				5'h16: voice_up_gain_db_out <= 5'h0C;
				5'h17: voice_up_gain_db_out <= 5'h15;
				5'h18: voice_up_gain_db_out <= 5'h16;
				5'h19: voice_up_gain_db_out <= 5'h17;
				5'h1A: voice_up_gain_db_out <= 5'h18;
				5'h1B: voice_up_gain_db_out <= 5'h19;
				default: voice_up_gain_db_out <= 5'h14;
			endcase
		end
	end

endmodule // bvc_ctrl_regs

// *** verification/bvc_ctrl_regs_asserts.sv ***
// Port assertions for the voice control register bank.
`timescale 1ns/1ns
module bvc_ctrl_regs_asserts (
	// Watched ports.
	input wire              core_clk_in,
	input wire              reset_n_in,
	input wire              ctl_sel_n_in,
	input wire              dsp_port_active_in,
	input wire              ctl_data_oe_out,
	input wire              codec_digital_reset_out,
	input wire              uplink_buffer_fill_out,
	input wire              downlink_filter_clear_out,
	input wire              dsp_tx_pins_oe_out,
	input wire              dsp_tx_pins_drive_low_out,
	input wire              voice_up_power_out,
	input wire              aux_input_amp_en_out,
	input wire              mic_input_amp_en_out,
	input wire [4:0]        voice_up_gain_code_out,
	input wire signed [4:0] voice_up_gain_db_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	property p_rst_fan;
		codec_digital_reset_out == uplink_buffer_fill_out
			&& codec_digital_reset_out == downlink_filter_clear_out;
	endproperty
	a_rst_fan: assert property (p_rst_fan) else $error("codec reset fan-out differs");
	property p_aux; aux_input_amp_en_out |-> voice_up_power_out; endproperty
	a_aux: assert property (p_aux) else $error("aux amp on without power");
	property p_mic; mic_input_amp_en_out |-> voice_up_power_out; endproperty
	a_mic: assert property (p_mic) else $error("mic amp on without power");
	// The port pin passes a two-stage synchroniser, hence the look two cycles back.
	property p_tx_low;
		dsp_tx_pins_drive_low_out |-> dsp_tx_pins_oe_out && !$past(dsp_port_active_in, 2);
	endproperty
	a_tx_low: assert property (p_tx_low) else $error("idle low while active");
	property p_tx_act;
		$past(dsp_port_active_in, 2) |-> dsp_tx_pins_oe_out && !dsp_tx_pins_drive_low_out;
	endproperty
	a_tx_act: assert property (p_tx_act) else $error("port pins not driven");
	// Settings only move inside a frame, so a long deselect must leave them alone.
	property p_hold;
		ctl_sel_n_in [*8] |-> $stable(codec_digital_reset_out) && $stable(voice_up_gain_code_out);
	endproperty
	a_hold: assert property (p_hold) else $error("setting changed outside frame");
	property p_gain_min; $past(voice_up_gain_code_out) == 5'h10 |-> voice_up_gain_db_out == 5'h14; endproperty
	a_gain_min: assert property (p_gain_min) else $error("lowest gain code wrong");
	property p_oe_idle; ctl_sel_n_in [*4] |-> !ctl_data_oe_out; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("data driven while deselected");
	c_read: cover property (ctl_data_oe_out);
	c_reset: cover property (codec_digital_reset_out);
	c_min: cover property (voice_up_gain_db_out == 5'h14);
	c_float: cover property (!dsp_tx_pins_oe_out);
endmodule // bvc_ctrl_regs_asserts
bind bvc_ctrl_regs bvc_ctrl_regs_asserts i_bvc_ctrl_regs_asserts (.*);

// *** verification/bvc_mcu_model.sv ***
// Serial controller model that frames register writes towards the bank.
`timescale 1ns/1ns
module bvc_mcu_model (
	// Serial control link.
	input  wire ctl_rdata_in,
	output reg  ctl_clk_out,
	output reg  ctl_sel_n_out,
	output reg  ctl_data_out
);
	reg       pol_reg = 1'h0;
	reg       pha_reg = 1'h0;
	reg       lsb_reg = 1'h0;
	reg [9:0] rx_reg = 10'h000;
	initial begin
		ctl_clk_out = 1'h0;
		ctl_sel_n_out = 1'h1;
		ctl_data_out = 1'h0;
	end
	// The clock rests at the polarity level, which set_mode changes while deselected, and only toggles while selected.
	task set_mode(input p, input h, input l);
		begin
			pol_reg = p;
			pha_reg = h;
			lsb_reg = l;
			ctl_clk_out = p;
			// A new rest level must settle before the next select, or it looks like a bit.
			#160;
		end
	endtask
	task send(input [15:0] w, input integer n);
		integer i;
		begin
			ctl_sel_n_out = 1'h0;
			for (i = 0; i < n; i = i + 1) begin
				if (!pha_reg) ctl_data_out = lsb_reg ? w[i] : w[15 - i];
				#80 ctl_clk_out = ~ctl_clk_out;
				if (!pha_reg && i >= 6) rx_reg[i - 6] = ctl_rdata_in;
				if (pha_reg) ctl_data_out = lsb_reg ? w[i] : w[15 - i];
				#80 ctl_clk_out = ~ctl_clk_out;
				if (pha_reg && i >= 6) rx_reg[i - 6] = ctl_rdata_in;
			end
			// A released line must not keep showing the last bit.
			#80 ctl_data_out = ~ctl_data_out;
			#80 ctl_sel_n_out = 1'h1;
		end
	endtask
endmodule // bvc_mcu_model

// *** verification/bvc_ctrl_regs_bench.sv ***
// Self-checking bench for the serial control register bank.
`timescale 1ns/1ns
module bvc_ctrl_regs_bench;
	localparam logic [31:0] ROWS [16] = '{
		{5'h07, 10'h000, 3'h6, 14'h0000}, {5'h07, 10'h000, 3'h2, 14'h0014},
		{5'h07, 10'h000, 3'h4, 14'h0008}, {5'h07, 10'h3FF, 3'h6, 14'h01FF},
		{5'h07, 10'h2AA, 3'h0, 14'h0021}, {5'h07, 10'h100, 3'h6, 14'h0002},
		{5'h09, 10'h000, 3'h6, 14'h0013}, {5'h09, 10'h3F8, 3'h7, 14'h000E},
		{5'h09, 10'h010, 3'h6, 14'h0010}, {5'h0A, 10'h0C0, 3'h6, 14'h001A},
		{5'h0A, 10'h3C1, 3'h6, 14'h3C1A}, {5'h0A, 10'h021, 3'h6, 14'h2214},
		{5'h0A, 10'h02E, 3'h6, 14'h02F5}, {5'h0A, 10'h036, 3'h6, 14'h0379},
		{5'h0A, 10'h022, 3'h6, 14'h0227}, {5'h0A, 10'h02C, 3'h6, 14'h02CC}};
	reg core_clk_in = 1'h0;
	reg reset_n_in = 1'h0;
	reg transmit_window_pin_in = 1'h1;
	reg receive_window_pin_in = 1'h1;
	reg dsp_port_active_in = 1'h0;
	wire ctl_clk_in, ctl_sel_n_in, ctl_data_in, ctl_data_out, ctl_data_oe_out;
	wire codec_digital_reset_out, uplink_buffer_fill_out, downlink_filter_clear_out;
	wire external_calibration_sel_out, uplink_power_down_out, downlink_power_down_out;
	wire midvolt_power_down_out, baseband_loopback_out, common_mode_sel_out;
	wire shift_lsb_first_out, tx_clock_continuous_out, slicer_bypass_out;
	wire serial_clock_polarity_out, serial_clock_phase_out, dsp_rx_clock_oe_out;
	wire dsp_tx_pins_oe_out, dsp_tx_pins_drive_low_out, voice_up_power_out;
	wire aux_input_amp_en_out, mic_input_amp_en_out, mic_bias_sel_out;
	wire [4:0] voice_up_gain_code_out;
	wire signed [4:0] voice_up_gain_db_out;
	integer mismatches = 0;
	integer checks = 0;
	integer cycles = 0;
	integer i;
	reg [4:0] code;
	reg oe_seen = 1'h0;
	bvc_ctrl_regs i_bvc_ctrl_regs (.*);
	bvc_mcu_model i_bvc_mcu_model (.ctl_rdata_in(ctl_data_out), .ctl_clk_out(ctl_clk_in),
		.ctl_sel_n_out(ctl_sel_n_in), .ctl_data_out(ctl_data_in));
	always @(posedge core_clk_in) if (ctl_data_oe_out) oe_seen = 1'h1;
	always #5 core_clk_in = ~core_clk_in;
	function [13:0] grp(input [4:0] a);
		case (a)
			5'h07: grp = {5'h00, codec_digital_reset_out, uplink_buffer_fill_out,
				downlink_filter_clear_out, external_calibration_sel_out, uplink_power_down_out,
				downlink_power_down_out, midvolt_power_down_out, baseband_loopback_out,
				common_mode_sel_out};
			5'h09: grp = {6'h00, shift_lsb_first_out, serial_clock_polarity_out,
				serial_clock_phase_out, dsp_rx_clock_oe_out, tx_clock_continuous_out,
				slicer_bypass_out, dsp_tx_pins_oe_out, dsp_tx_pins_drive_low_out};
			default: grp = {voice_up_power_out, aux_input_amp_en_out, mic_input_amp_en_out,
				mic_bias_sel_out, voice_up_gain_code_out, voice_up_gain_db_out};
		endcase
	endfunction
	task chk(input [13:0] seen, input [13:0] exp, input string nm);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("[ERR] %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task wr(input [4:0] a, input [9:0] d);
		begin
			i_bvc_mcu_model.send({d, a, 1'h0}, 16);
			repeat (4) @(negedge core_clk_in);
		end
	endtask
	task rd(input [4:0] a, input [9:0] exp);
		begin
			oe_seen = 1'h0;
			i_bvc_mcu_model.send({10'h000, a, 1'h1}, 16);
			repeat (4) @(negedge core_clk_in);
			chk({4'h0, i_bvc_mcu_model.rx_reg}, {4'h0, exp}, "read data");
			chk({13'h0000, oe_seen}, 14'h0001, "read drive");
			chk({13'h0000, ctl_data_oe_out}, 14'h0000, "read release");
		end
	endtask
	task results;
		begin
			$display("checks %0d mismatches %0d", checks, mismatches);
			if (mismatches == 0 && checks > 0) begin
				$display("Regression OK");
			end else begin
				$display("Regression broken");
			end
			$finish;
		end
	endtask
	// A hang ends the run as a failure rather than stalling the regression.
	always @(posedge core_clk_in) begin
		cycles = cycles + 1;
		if (cycles == 40000) begin
			mismatches = mismatches + 1;
			results;
		end
	end
	initial begin
		repeat (20) @(negedge core_clk_in);
		reset_n_in = 1'h1;
		repeat (4) @(negedge core_clk_in);
		for (i = 0; i < 16; i = i + 1) begin
			{transmit_window_pin_in, receive_window_pin_in, dsp_port_active_in} = ROWS[i][16:14];
			wr(ROWS[i][31:27], ROWS[i][26:17]);
			chk(grp(ROWS[i][31:27]), ROWS[i][13:0], "row");
		end
		i_bvc_mcu_model.send({10'h3FF, 5'h0A, 1'h0}, 10);
		repeat (4) @(negedge core_clk_in);
		chk(grp(5'h0A), 14'h02CC, "short frame");
		wr(5'h1F, 10'h3FF);
		chk(grp(5'h0A), 14'h02CC, "unmapped");
		chk(grp(5'h07), 14'h0002, "unmapped");
		for (i = 0; i < 8; i = i + 1) begin
			wr(5'h09, i[9:0]);
			i_bvc_mcu_model.set_mode(i[0], i[1], i[2]);
			code = i[4:0] + 5'h08;
			wr(5'h0A, {4'h0, code, 1'h0});
			chk(grp(5'h09), {6'h00, i[2], i[0], i[1], 5'h13}, "mode");
			chk(grp(5'h0A), {4'h0, code, i < 5 ? code - 5'h06 : 5'h14}, "gain");
		end
		rd(5'h0A, 10'h01E);
		rd(5'h07, 10'h100);
		rd(5'h1F, 10'h000);
		wr(5'h09, 10'h004);
		i_bvc_mcu_model.set_mode(1'h0, 1'h0, 1'h1);
		rd(5'h09, 10'h004);
		wr(5'h09, 10'h000);
		i_bvc_mcu_model.set_mode(1'h0, 1'h0, 1'h0);
		reset_n_in = 1'h0;
		repeat (3) @(negedge core_clk_in);
		reset_n_in = 1'h1;
		repeat (4) @(negedge core_clk_in);
		chk(grp(5'h07), 14'h0000, "reset");
		chk(grp(5'h09), 14'h0013, "reset");
		chk(grp(5'h0A), 14'h001A, "reset");
		results;
	end
endmodule // bvc_ctrl_regs_bench
